// ---- inc/supervision_pkg.sv ----
// constants and types shared by the supervision timer files
// assumes one 200 MHz clock that also serves as the machine cycle
package supervision_pkg;
  // register byte addresses on the avalon slave
  localparam logic [7:0] CTRL_OFFSET = 8'h14;
  localparam logic [7:0] MISC_OFFSET = 8'h4c;
  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h7f;
  localparam logic [7:0] MISC_RESET = 8'h00;
  // field positions
  localparam int ACTIVATE_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam int BYPASS_BIT = 7;
  // countdown value whose step clears the top bit
  localparam logic [6:0] ROLL_VALUE = 7'h40;
  // machine cycles per countdown step
  localparam int PRESCALE_CYCLES = 65536;
  // clock and reset pulse timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int RESET_LOW_NS = 500;
  localparam int RESET_LOW_CYCLES = (RESET_LOW_NS / CLK_PERIOD_NS < 1) ? 1 : RESET_LOW_NS / CLK_PERIOD_NS;
  // clocks from wake-up to counting again
  localparam int WAKE_DELAY_CLOCKS = 514;
  // low-power sequencing
  typedef enum logic [1:0] {
    st_running,
    st_halted,
    st_waking
  } halt_state_type;
endpackage

// ---- inc/supervision_link_if.sv ----
// signals between the supervision core, its prescaler and its reset stretcher
// assumes all parties share one clock
`timescale 1ns/100ps
interface supervision_link_if;
  logic run;
  logic tick;
  logic fire;
  logic busy;
  modport core (output run, input tick, output fire, input busy);
  modport prescale (input run, output tick);
  modport stretch (input fire, output busy);
endinterface

// ---- hw/step_prescaler.sv ----
// prescaler giving one countdown step every PRESCALE machine cycles
// assumes run drops while the oscillator is considered stopped
`timescale 1ns/100ps
module step_prescaler #(
  parameter int PRESCALE = 65536
) (
  input wire logic clk,
  input wire logic rst,
  supervision_link_if.prescale link
);
  import supervision_pkg::*;

  localparam logic [16:0] LAST = 17'(PRESCALE - 1);

  logic [16:0] phase_r;

  // tick on the last phase while running
  assign link.tick = link.run && (phase_r == LAST);

  // phase holds while frozen, wraps after the last count
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= 17'h0_0000;
    end else if (link.run) begin
      phase_r <= (phase_r == LAST) ? 17'h0_0000 : phase_r + 17'h0_0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_phase_frozen: assert property (!link.run |=> phase_r == $past(phase_r))
    else $error("prescaler moved while frozen");
endmodule

// ---- hw/reset_stretcher.sv ----
// stretcher holding the reset request for a fixed number of cycles
// assumes fire is a one-cycle request from the core
`timescale 1ns/100ps
module reset_stretcher (
  input wire logic clk,
  input wire logic rst,
  supervision_link_if.stretch link
);
  import supervision_pkg::*;

  localparam logic [6:0] LAST = 7'(RESET_LOW_CYCLES - 1);
  localparam int PULSE_LEN = RESET_LOW_CYCLES;

  logic busy_r;
  logic [6:0] cnt_r;

  assign link.busy = busy_r;

  // start on fire, end after the pulse length; fires while busy merge, except one on the last cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= 7'h00;
    end else if (!busy_r) begin
      busy_r <= link.fire;
      cnt_r <= 7'h00;
    end else begin
      // a cause landing on the last cycle starts a fresh pulse instead of being lost
      busy_r <= (cnt_r != LAST) || link.fire;
      cnt_r <= (cnt_r == LAST) ? 7'h00 : cnt_r + 7'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_pulse_width: assert property ($rose(busy_r) |-> ##[PULSE_LEN:PULSE_LEN] !busy_r)
    else $error("reset pulse length wrong");
  a_pulse_held: assert property ($rose(busy_r) |=> busy_r [*8])
    else $error("reset pulse dropped early");
endmodule

// ---- hw/supervision_timer.sv ----
// windowed supervision timer with avalon-mm register access
// assumes halt_exec, usb_suspended and ext_wake come from logic on clk
`timescale 1ns/100ps
module supervision_timer #(
  parameter int PRESCALE = supervision_pkg::PRESCALE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic permanent_strap,
  input wire logic halt_exec,
  input wire logic usb_suspended,
  input wire logic ext_wake,
  output logic halt_enter,
  output logic halted,
  output logic reset_out_n
);
  import supervision_pkg::*;

  localparam logic [9:0] WAKE_LAST = 10'(WAKE_DELAY_CLOCKS - 1);
  localparam int WAKE_SPAN = WAKE_DELAY_CLOCKS + 1;

  supervision_link_if link ();

  logic ack_r;
  logic [31:0] rdata_r;
  logic wr_ctrl;
  logic wr_misc;
  logic activate_r;
  logic [6:0] count_r;
  logic bypass_r;
  logic permanent_r;
  logic active_eff;
  logic roll_fire;
  logic soft_fire;
  logic halt_fire;
  logic halt_ok;
  halt_state_type state_r;
  halt_state_type state_nxt;
  logic [9:0] wake_cnt_r;
  logic halted_r;

  step_prescaler #(
    .PRESCALE(PRESCALE)
  ) u_prescaler (
    .clk(clk),
    .rst(rst),
    .link(link)
  );

  reset_stretcher u_stretcher (
    .clk(clk),
    .rst(rst),
    .link(link)
  );

  // bus handshake: every access answers on the second cycle
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // read data captured in the waiting cycle, zero when unmapped
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      if (avs_address == CTRL_OFFSET) begin
        rdata_r <= {24'h00_0000, activate_r, count_r};
      end else if (avs_address == MISC_OFFSET) begin
        rdata_r <= {24'h00_0000, bypass_r, 7'h00};
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  // writes take effect at the edge that ends the answering cycle, one edge after the wait ends
  assign wr_ctrl = avs_write && ack_r && avs_byteenable[0] && (avs_address == CTRL_OFFSET);
  assign wr_misc = avs_write && ack_r && avs_byteenable[0] && (avs_address == MISC_OFFSET);

  // configuration strap caught while reset is held
  always_ff @(posedge clk) begin
    if (rst) begin
      permanent_r <= permanent_strap;
    end
  end

  // activate bit: set by software, cleared only by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      activate_r <= CTRL_RESET[ACTIVATE_BIT];
    end else if (wr_ctrl && avs_writedata[ACTIVATE_BIT]) begin
      activate_r <= 1'b1;
    end
  end

  // permanent mode overrides the activate bit
  assign active_eff = activate_r || permanent_r;

  // countdown: a refresh wins over a step in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= CTRL_RESET[6:0];
    end else if (wr_ctrl) begin
      count_r <= avs_writedata[6:0];
    end else if (link.tick) begin
      count_r <= count_r - 7'h01;
    end
  end

  // halt bypass bit, other bits of the register read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      bypass_r <= MISC_RESET[BYPASS_BIT];
    end else if (wr_misc) begin
      bypass_r <= avs_writedata[BYPASS_BIT];
    end
  end

  // reset sources: roll-over, software force, halt while active
  assign roll_fire = link.tick && !wr_ctrl && active_eff && (count_r == ROLL_VALUE);
  assign soft_fire = wr_ctrl && (avs_writedata[ACTIVATE_BIT] || permanent_r)
    && !avs_writedata[TOP_BIT];
  assign halt_fire = halt_exec && (state_r == st_running) && active_eff
    && !bypass_r && !usb_suspended;
  assign halt_ok = halt_exec && (state_r == st_running) && !halt_fire;
  assign link.fire = roll_fire || soft_fire || halt_fire;
  assign halt_enter = halt_ok;

  // counting stops while halted and while waking
  assign link.run = (state_r == st_running);

  // low-power sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      st_running: begin
        if (halt_ok) begin
          state_nxt = st_halted;
        end
      end
      st_halted: begin
        if (ext_wake) begin
          state_nxt = st_waking;
        end
      end
      st_waking: begin
        if (wake_cnt_r == WAKE_LAST) begin
          state_nxt = st_running;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= st_running;
    end else begin
      state_r <= state_nxt;
    end
  end

  // wake delay counter
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_cnt_r <= 10'h000;
    end else if (state_r == st_waking) begin
      wake_cnt_r <= wake_cnt_r + 10'h001;
    end else begin
      wake_cnt_r <= 10'h000;
    end
  end

  // status outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      halted_r <= 1'b0;
    end else begin
      halted_r <= (state_nxt != st_running);
    end
  end

  assign halted = halted_r;
  assign reset_out_n = !link.busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tick_steps_down: assert property (link.tick && !wr_ctrl |=> count_r == $past(count_r) - 7'h01)
    else $error("countdown did not step");
  a_roll_resets: assert property (roll_fire |=> !reset_out_n)
    else $error("roll-over did not reset");
  a_free_running: assert property (!active_eff && link.tick && !wr_ctrl |=> count_r != $past(count_r))
    else $error("inactive countdown stopped");
  a_refresh_loads: assert property (wr_ctrl |=> count_r == $past(avs_writedata[6:0]))
    else $error("refresh value not loaded");
  a_activate_sticky: assert property (activate_r |=> activate_r)
    else $error("activate bit cleared without reset");
  a_soft_force: assert property (wr_ctrl && avs_writedata[7] && !avs_writedata[6] |=> !reset_out_n)
    else $error("forced reset missing");
  a_permanent_active: assert property (permanent_r && link.tick && !wr_ctrl
    && count_r == ROLL_VALUE |=> !reset_out_n)
    else $error("permanent mode did not reset");
  a_halt_frozen: assert property (state_r == st_halted |-> !link.tick && !roll_fire)
    else $error("countdown moved in halt");
  a_halt_resets: assert property (halt_exec && state_r == st_running && active_eff && !bypass_r
    && !usb_suspended |=> !reset_out_n && halted_r == 1'b0)
    else $error("halt did not reset");
  a_halt_bypass: assert property (halt_exec && state_r == st_running && (bypass_r || usb_suspended)
    |-> !halt_fire ##1 state_r == st_halted)
    else $error("halt bypass failed");
  a_wake_delay: assert property (state_r == st_halted && ext_wake
    |-> ##[WAKE_SPAN:WAKE_SPAN] state_r == st_running)
    else $error("wake delay wrong");
  a_misc_read: assert property (ack_r && avs_read && avs_address == MISC_OFFSET
    |-> avs_readdata[6:0] == 7'h00)
    else $error("misc reserved bits not zero");
  a_strap_stable: assert property (1'b1 |=> permanent_r == $past(permanent_r))
    else $error("strap changed outside reset");
endmodule

// ---- test/windowed_supervision_timer_bench.sv ----
// self-checking bench for the supervision timer, prescaler shortened to 8 cycles
// assumes the package, link interface and design files are compiled first
`timescale 1ns/100ps
module windowed_supervision_timer_bench;
  import supervision_pkg::*;
  localparam int PS = 8;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, permanent_strap;
  logic halt_exec, usb_suspended, ext_wake, halt_enter, halted, reset_out_n;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, r1;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int low_cycles = 0;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [3:0] be; logic [7:0] e;} row_type;
  row_type rows [5];

  supervision_timer #(.PRESCALE(PS)) dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .permanent_strap(permanent_strap), .halt_exec(halt_exec), .usb_suspended(usb_suspended),
    .ext_wake(ext_wake), .halt_enter(halt_enter), .halted(halted), .reset_out_n(reset_out_n));

  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // reset low-time counter and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (reset_out_n === 1'b0) low_cycles <= low_cycles + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic do_reset(input logic s);
    permanent_strap <= s;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    low_cycles = 0;
  endtask

  task automatic halt_pulse(input logic e);
    halt_exec <= 1'b1;
    #1 chk("halt_enter", {31'h0000_0000, e}, {31'h0000_0000, halt_enter});
    @(posedge clk);
    halt_exec <= 1'b0;
  endtask

  // waits out any reset pulse, then checks its length
  task automatic settle_low(input int e);
    repeat (140) @(posedge clk);
    chk("reset_low_cycles", e, low_cycles);
    low_cycles = 0;
  endtask

  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    permanent_strap = 1'b0;
    halt_exec = 1'b0;
    usb_suspended = 1'b0;
    ext_wake = 1'b0;
    rows = '{'{MISC_OFFSET, 8'hff, 4'h1, 8'h80}, '{MISC_OFFSET, 8'h7f, 4'h1, 8'h00},
      '{MISC_OFFSET, 8'h80, 4'h0, 8'h00}, '{8'h20, 8'hff, 4'h1, 8'h00}, '{MISC_OFFSET, 8'h80, 4'h1, 8'h80}};
    do_reset(1'b0);
    bus(1'b0, CTRL_OFFSET, 8'h00, 4'h1);
    chk("ctrl_reset", {24'h00_0000, CTRL_RESET}, rd);
    bus(1'b0, MISC_OFFSET, 8'h00, 4'h1);
    chk("misc_reset", {24'h00_0000, MISC_RESET}, rd);
    // register rows: write then read back
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].be);
      bus(1'b0, rows[i].a, 8'h00, 4'h1);
      chk("row_readback", {24'h00_0000, rows[i].e}, rd);
    end
    // inactive timer loaded with 45h steps down from 44h to 3Fh without any reset
    bus(1'b1, CTRL_OFFSET, 8'h45, 4'h1);
    bus(1'b0, CTRL_OFFSET, 8'h00, 4'h1);
    r1 = rd;
    repeat (37) @(posedge clk);
    bus(1'b0, CTRL_OFFSET, 8'h00, 4'h1);
    chk("count_step", r1 - 32'h0000_0005, rd);
    chk("inactive_low", 0, low_cycles);
    // software forced reset, then activate cannot be cleared
    bus(1'b1, CTRL_OFFSET, 8'h80, 4'h1);
    settle_low(RESET_LOW_CYCLES);
    bus(1'b1, CTRL_OFFSET, 8'h7f, 4'h1);
    bus(1'b0, CTRL_OFFSET, 8'h00, 4'h1);
    chk("activate_kept", 32'h0000_0001, {31'h0000_0000, rd[ACTIVATE_BIT]});
    bus(1'b1, CTRL_OFFSET, 8'hc1, 4'h1);
    settle_low(RESET_LOW_CYCLES);
    do_reset(1'b0);
    bus(1'b0, CTRL_OFFSET, 8'h00, 4'h1);
    chk("activate_cleared", 32'h0000_0000, {31'h0000_0000, rd[ACTIVATE_BIT]});
    // halt with bypass clear resets instead
    bus(1'b1, CTRL_OFFSET, 8'hff, 4'h1);
    halt_pulse(1'b0);
    settle_low(RESET_LOW_CYCLES);
    chk("halted_no", 32'h0000_0000, {31'h0000_0000, halted});
    // halt with bypass set freezes the count
    bus(1'b1, MISC_OFFSET, 8'h80, 4'h1);
    bus(1'b1, CTRL_OFFSET, 8'hc1, 4'h1);
    halt_pulse(1'b1);
    repeat (100) @(posedge clk);
    bus(1'b0, CTRL_OFFSET, 8'h00, 4'h1);
    r1 = rd;
    repeat (40) @(posedge clk);
    bus(1'b0, CTRL_OFFSET, 8'h00, 4'h1);
    chk("frozen_count", r1, rd);
    chk("halt_low", 0, low_cycles);
    ext_wake <= 1'b1;
    @(posedge clk);
    ext_wake <= 1'b0;
    repeat (WAKE_DELAY_CLOCKS - 1) @(posedge clk);
    #1 chk("waking", 32'h0000_0001, {31'h0000_0000, halted});
    @(posedge clk);
    #1 chk("woken", 32'h0000_0000, {31'h0000_0000, halted});
    settle_low(RESET_LOW_CYCLES);
    // usb suspend blocks the halt reset
    do_reset(1'b0);
    bus(1'b1, CTRL_OFFSET, 8'hff, 4'h1);
    usb_suspended <= 1'b1;
    halt_pulse(1'b1);
    settle_low(0);
    usb_suspended <= 1'b0;
    // permanent mode caught at reset, activate bit ignored
    do_reset(1'b1);
    permanent_strap <= 1'b0;
    bus(1'b1, CTRL_OFFSET, 8'h41, 4'h1);
    settle_low(RESET_LOW_CYCLES);
    finish_test();
  end
endmodule
